// [hw/awg_pkg.sv]
// shared constants and carrier types for the set-value sequencer
// assumes one 50 MHz clock and a 0.1 ms sample tick derived from it
package awg_pkg;
  // timing: sample tick is the finest programmable time step
  localparam int CLK_NS = 20;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  // limits of the programmable values, times are in sample ticks
  localparam logic [6:0] PT_MAX = 7'h63;
  localparam logic [28:0] TIME_MAX = 29'h15752a00;
  localparam logic [13:0] FREQ_MAX = 14'h2710;
  localparam logic [8:0] ANGLE_MAX = 9'h167;
  localparam logic [2:0] CRANK_LAST = 3'h4;
  localparam logic [1:0] TRAP_LAST = 2'h3;
  // set values are counts, NOMINAL counts equal the rated value
  localparam logic signed [15:0] NOMINAL = 16'sh2710;
  localparam logic signed [15:0] HALF_NOM = 16'sh1388;
  // phase steps: 2^32 per 10 kHz sample, 2^32 per 360 degrees
  localparam logic [31:0] HZ_STEP = 32'h00068db9;
  localparam logic [31:0] DEG_STEP = 32'h00b60b61;
  // sweep check: df * 100000 >= 93 * ticks means df/s >= 9.3
  localparam logic [46:0] RATIO_NUM = 47'h186a0;
  localparam logic [46:0] RATIO_DEN = 47'h5d;
  // amplitude must move one count per 2^16 ticks at least
  localparam int AMP_SHIFT = 16;
  localparam int SV_W = 16;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    MODE_TRAP = 2'b00,
    MODE_CRANK = 2'b01,
    MODE_ARB = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_PAUSE = 2'b10
  } run_t;

  typedef struct packed {
    logic signed [15:0] sine_start_amp;
    logic signed [15:0] sine_end_amp;
    logic signed [15:0] ramp_start_offset;
    logic signed [15:0] ramp_end_offset;
    logic [13:0] sine_start_freq;
    logic [13:0] sine_end_freq;
    logic [8:0] start_angle;
    logic [28:0] seg_time;
  } point_t;

  typedef struct packed {
    logic signed [15:0] volt_start;
    logic signed [15:0] volt_end;
    logic [28:0] seg_time;
  } crank_seg_t;

  typedef struct packed {
    logic signed [15:0] amp;
    logic signed [15:0] offset;
    logic [3:0][28:0] seg_time;
  } trap_cfg_t;

  typedef struct packed {
    logic [15:0] src_curr;
    logic [15:0] src_pwr;
    logic [15:0] snk_curr;
    logic [15:0] snk_pwr;
  } limits_t;

  // preset cranking pulse, listed from the fifth segment to the first
  localparam crank_seg_t [4:0] CRANK_DEF = '{
    '{16'sh0960, 16'sh0960, 29'h00000064},
    '{16'sh04b0, 16'sh0960, 29'h00000fa0},
    '{16'sh04b0, 16'sh04b0, 29'h00000c8},
    '{16'sh0320, 16'sh04b0, 29'h00000032},
    '{16'sh0960, 16'sh0320, 29'h00000032}
  };
endpackage

// [hw/sample_fifo.sv]
// flip-flop fifo carrying set-value samples to the regulation loop
// assumes a power-of-two depth and a consumer on the same clock
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [W-1:0] head;
    logic has;
    logic full;
  } fifo_st_t;
  fifo_st_t st;
  fifo_st_t next_st;
  logic push;
  logic pop;

  // outputs are flops that mirror the state just registered
  assign in_ready = !st.full;
  assign out_valid = st.has;
  assign out_data = st.head;

  // pointers wrap naturally since depth is a power of two
  always_comb begin
    next_st = st;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: next_st.cnt = st.cnt + 1'b1;
      2'b01: next_st.cnt = st.cnt - 1'b1;
      default: next_st.cnt = st.cnt;
    endcase
    // head and flags taken from the next state, so no output mux
    next_st.head = next_st.mem[next_st.rd];
    next_st.has = next_st.cnt != '0;
    next_st.full = next_st.cnt == (AW + 1)'(DEPTH);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// [hw/waveform_sequencer.sv]
// set-value sequencer: trapezoid, cranking curve, arbitrary points
// assumes parameter store and regulation loop on the same clock
`timescale 1ns/1ps
module waveform_sequencer
  import awg_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire mode_t mode_sel,
  input wire logic tgt_curr,
  input wire limits_t limits,
  input wire trap_cfg_t trap_cfg,
  input wire logic crank_we,
  input wire logic [2:0] crank_idx,
  input wire crank_seg_t crank_data,
  input wire logic [9:0] crank_cycles,
  input wire logic [28:0] repeat_pause_time,
  input wire logic signed [15:0] static_volt,
  input wire logic pt_we,
  input wire logic [6:0] pt_idx,
  input wire point_t pt_data,
  input wire logic [6:0] arb_first,
  input wire logic [6:0] arb_last,
  input wire logic [9:0] arb_cycles,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_off,
  input wire logic alarm_pin,
  input wire logic sv_ready,
  output logic [15:0] sv_data,
  output logic sv_valid,
  output logic sv_is_curr,
  output logic output_on,
  output logic running,
  output logic sink_only,
  output logic source_only,
  output logic alarm_flag,
  output logic pt_accept,
  output logic pt_reject,
  output logic start_reject
);
  typedef struct packed {
    run_t state;
    mode_t mode;
    logic curr;
    logic run;
    logic on;
    logic alarm;
    logic alarm_lvl;
    logic [2:0] sync;
    logic sink;
    logic source;
    logic acc;
    logic rej;
    logic srej;
    logic [15:0] tick;
    logic [6:0] seg;
    logic [6:0] first;
    logic [6:0] last;
    logic [9:0] cnt;
    logic [28:0] elapsed;
    logic [31:0] phase;
    logic [4:0][$bits(crank_seg_t)-1:0] crank;
    logic [98:0][$bits(point_t)-1:0] pts;
  } seq_st_t;

  seq_st_t st;
  seq_st_t next_st;
  point_t cur;
  point_t pnew;
  crank_seg_t cseg;
  logic tick_now, adv, seg_end, fifo_ready, pass_done;
  logic ratio_ok, amp_ok, rng_ok, ofs_ok, pt_ok, range_ok;
  logic signed [15:0] dc, amp, ac, fr, sample, top, lo;
  logic signed [16:0] da;
  logic [13:0] df;
  logic [31:0] inc;
  logic [28:0] el1;
  logic [9:0] cycles;
  logic [6:0] nxt;

  // (b-a)*el/dur added to a; wide enough for the longest segment
  function automatic logic signed [15:0] lerp(
    input logic signed [15:0] a,
    input logic signed [15:0] b,
    input logic [28:0] el,
    input logic [28:0] dur
  );
    logic signed [47:0] d;
    d = 48'(b) - 48'(a);
    d = d * $signed({19'h0, el});
    if (dur != '0) begin
      d = d / $signed({19'h0, dur});
    end
    return 16'(48'(a) + d);
  endfunction

  // parabolic sine: 4p(1-p) per half wave, top bit gives the sign
  function automatic logic signed [15:0] sine_of(
    input logic [31:0] ph,
    input logic signed [15:0] a
  );
    logic [29:0] sq;
    logic signed [33:0] m;
    sq = {15'h0, ph[30:16]} * {15'h0, 15'h7fff - ph[30:16]};
    m = 34'(a) * $signed({18'h0, 16'(sq >> 13)});
    m = m >>> 15;
    return ph[31] ? -16'(m) : 16'(m);
  endfunction

  // start angle of a stored point as a phase word
  function automatic logic [31:0] phase_of(
    input logic [$bits(point_t)-1:0] v
  );
    point_t p;
    p = point_t'(v);
    return 32'(p.start_angle) * DEG_STEP;
  endfunction

  function automatic logic [16:0] mag(input logic signed [15:0] v);
    return (v < 0) ? 17'(-17'(v)) : 17'(v);
  endfunction

  function automatic logic off_ok(
    input logic signed [15:0] o,
    input logic signed [15:0] a,
    input logic c
  );
    logic [16:0] lim;
    lim = 17'(NOMINAL) - mag(a);
    if (c) begin
      return mag(o) <= lim;
    end
    return (o >= 0) && (17'(o) >= mag(a)) && (17'(o) <= lim);
  endfunction

  assign top = trap_cfg.offset + trap_cfg.amp;
  assign cseg = crank_seg_t'(st.crank[st.seg[2:0]]);
  assign pnew = pt_data;

  // segment currently played, all modes mapped onto one point shape
  always_comb begin
    cur = '0;
    case (st.mode)
      MODE_TRAP: begin
        cur.seg_time = trap_cfg.seg_time[st.seg[1:0]];
        case (st.seg[1:0])
          2'h0: begin
            cur.ramp_start_offset = trap_cfg.offset;
            cur.ramp_end_offset = top;
          end
          2'h1: begin
            cur.ramp_start_offset = top;
            cur.ramp_end_offset = top;
          end
          2'h2: begin
            cur.ramp_start_offset = top;
            cur.ramp_end_offset = trap_cfg.offset;
          end
          default: begin
            cur.ramp_start_offset = trap_cfg.offset;
            cur.ramp_end_offset = trap_cfg.offset;
          end
        endcase
      end
      MODE_CRANK: begin
        cur.ramp_start_offset = cseg.volt_start;
        cur.ramp_end_offset = cseg.volt_end;
        cur.seg_time = cseg.seg_time;
      end
      MODE_ARB: cur = point_t'(st.pts[st.seg]);
      default: cur = '0;
    endcase
  end

  // sample value in ST_RUN: DC ramp plus swept sine, both from elapsed ticks
  always_comb begin
    el1 = st.elapsed + 29'h1;
    dc = lerp(cur.ramp_start_offset, cur.ramp_end_offset,
              st.elapsed, cur.seg_time);
    amp = lerp(cur.sine_start_amp, cur.sine_end_amp,
               st.elapsed, cur.seg_time);
    fr = lerp($signed({2'b0, cur.sine_start_freq}),
              $signed({2'b0, cur.sine_end_freq}),
              st.elapsed, cur.seg_time);
    inc = 32'(fr[13:0]) * HZ_STEP;
    ac = sine_of(st.phase, amp);
    if (cur.sine_start_freq == '0 && cur.sine_end_freq == '0) begin
      ac = '0;
    end
    case (st.state)
      ST_RUN: sample = dc + ac;
      ST_PAUSE: sample = static_volt;
      default: sample = (st.on && !st.curr) ? static_volt : '0;
    endcase
    if (st.state == ST_PAUSE) begin
      seg_end = el1 >= repeat_pause_time;
    end else begin
      seg_end = el1 >= cur.seg_time;
    end
  end

  // point checks; a rejected write leaves the stored point untouched
  always_comb begin
    if (pnew.sine_end_freq >= pnew.sine_start_freq) begin
      df = pnew.sine_end_freq - pnew.sine_start_freq;
    end else begin
      df = pnew.sine_start_freq - pnew.sine_end_freq;
    end
    ratio_ok = (df == '0) || (47'(df) * RATIO_NUM >=
               47'(pnew.seg_time) * RATIO_DEN);
    da = 17'(pnew.sine_end_amp) - 17'(pnew.sine_start_amp);
    if (da < 0) begin
      da = -da;
    end
    amp_ok = (da == '0) ||
             ((34'(da) << AMP_SHIFT) >= 34'(pnew.seg_time));
    lo = tgt_curr ? -HALF_NOM : 16'sh0000;
    rng_ok = pnew.sine_start_amp >= lo && pnew.sine_end_amp >= lo &&
             pnew.sine_start_amp <= HALF_NOM &&
             pnew.sine_end_amp <= HALF_NOM;
    ofs_ok = off_ok(pnew.ramp_start_offset, pnew.sine_start_amp,
                    tgt_curr) && off_ok(pnew.ramp_end_offset,
                    pnew.sine_end_amp, tgt_curr);
    pt_ok = ratio_ok && amp_ok && rng_ok && ofs_ok &&
            pnew.sine_start_freq <= FREQ_MAX &&
            pnew.sine_end_freq <= FREQ_MAX &&
            pnew.start_angle <= ANGLE_MAX &&
            pnew.seg_time != '0 && pnew.seg_time <= TIME_MAX &&
            pt_idx != '0 && pt_idx <= PT_MAX;
    range_ok = arb_first != '0 && arb_first <= arb_last &&
               arb_last <= PT_MAX;
  end

  // engine only moves when the fifo takes the sample: back-pressure
  assign tick_now = st.tick == 16'(TICK_CYC - 1);
  assign adv = tick_now && fifo_ready;
  assign cycles = (st.mode == MODE_CRANK) ? crank_cycles : arb_cycles;
  assign pass_done = cycles != '0 && (st.cnt + 10'h1) >= cycles;

  always_comb begin
    next_st = st;
    next_st.acc = 1'b0;
    next_st.rej = 1'b0;
    next_st.srej = 1'b0;
    nxt = st.seg + 7'h1;
    next_st.sync = {st.sync[1:0], alarm_pin};
    if (st.sync[2] == st.sync[1]) begin
      next_st.alarm_lvl = st.sync[2];
    end
    next_st.sink = limits.src_curr == '0 || limits.src_pwr == '0;
    next_st.source = limits.snk_curr == '0 ||
                     limits.snk_pwr == '0;
    if (!tick_now) begin
      next_st.tick = st.tick + 16'h1;
    end else if (fifo_ready) begin
      next_st.tick = '0;
    end
    if (crank_we && crank_idx <= CRANK_LAST) begin
      next_st.crank[crank_idx] = crank_data;
    end
    if (pt_we) begin
      next_st.acc = pt_ok;
      next_st.rej = !pt_ok;
      if (pt_ok) begin
        next_st.pts[pt_idx - 7'h1] = pt_data;
      end
    end
    // command priority: alarm, output off, stop, start
    if (st.alarm_lvl) begin
      next_st.state = ST_IDLE;
      next_st.on = 1'b0;
      next_st.alarm = 1'b1;
    end else if (cmd_off) begin
      next_st.state = ST_IDLE;
      next_st.on = 1'b0;
    end else if (cmd_stop) begin
      next_st.state = ST_IDLE;
    end else if (cmd_start && st.state == ST_IDLE) begin
      if (mode_sel == MODE_ARB && !range_ok) begin
        next_st.srej = 1'b1;
      end else begin
        next_st.state = ST_RUN;
        next_st.on = 1'b1;
        next_st.alarm = 1'b0;
        next_st.mode = mode_sel;
        next_st.curr = tgt_curr && mode_sel != MODE_CRANK;
        next_st.first = arb_first - 7'h1;
        next_st.last = arb_last - 7'h1;
        next_st.seg = (mode_sel == MODE_ARB) ? arb_first - 7'h1 : '0;
        next_st.elapsed = '0;
        next_st.cnt = '0;
        next_st.phase = '0;
        if (mode_sel == MODE_ARB) begin
          next_st.phase = phase_of(st.pts[arb_first - 7'h1]);
        end
      end
    end else if (adv && st.state != ST_IDLE) begin
      next_st.elapsed = el1;
      next_st.phase = st.phase + inc;
      if (seg_end && st.state == ST_PAUSE) begin
        next_st.state = ST_RUN;
        next_st.elapsed = '0;
        next_st.seg = '0;
      end else if (seg_end) begin
        next_st.elapsed = '0;
        next_st.seg = nxt;
        case (st.mode)
          MODE_TRAP: next_st.seg = {5'h0, st.seg[1:0] + 2'h1};
          MODE_CRANK: begin
            if (st.seg[2:0] == CRANK_LAST) begin
              next_st.seg = '0;
              next_st.cnt = st.cnt + 10'h1;
              if (pass_done) begin
                next_st.state = ST_IDLE;
              end else if (crank_cycles != 10'h1) begin
                next_st.state = ST_PAUSE;
              end
            end
          end
          MODE_ARB: begin
            if (st.seg == st.last) begin
              next_st.seg = st.first;
              next_st.cnt = st.cnt + 10'h1;
              if (pass_done) begin
                next_st.state = ST_IDLE;
              end
            end
            next_st.phase = phase_of(st.pts[next_st.seg]);
          end
          default: next_st.state = ST_IDLE;
        endcase
        if (cycles == '0) begin
          next_st.cnt = '0;
        end
      end
    end
    next_st.run = next_st.state != ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.crank <= CRANK_DEF;
    end else begin
      st <= next_st;
    end
  end

  sample_fifo #(
    .W(SV_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(tick_now),
    .in_ready(fifo_ready),
    .in_data(sample),
    .out_valid(sv_valid),
    .out_ready(sv_ready),
    .out_data(sv_data)
  );

  assign sv_is_curr = st.curr;
  assign output_on = st.on;
  assign running = st.run;
  assign sink_only = st.sink;
  assign source_only = st.source;
  assign alarm_flag = st.alarm;
  assign pt_accept = st.acc;
  assign pt_reject = st.rej;
  assign start_reject = st.srej;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_halt_off;
    !running && !output_on;
  endsequence
  sequence s_stop_req;
    cmd_stop && !cmd_off && !st.alarm_lvl && output_on;
  endsequence

  a_alarm_halts: assert property (
    st.alarm_lvl |=> s_halt_off ##0 alarm_flag)
    else $error("alarm did not halt the output");
  a_stop_keeps_on: assert property (
    s_stop_req |=> !running && output_on)
    else $error("stop changed the output state");
  a_off_disables: assert property (
    cmd_off |=> !output_on ##1 !output_on || cmd_start)
    else $error("output off did not disable");
  a_sink_only: assert property (
    limits.src_curr == '0 || limits.src_pwr == '0 |=> sink_only)
    else $error("zero source limit not sink only");
  a_source_only: assert property (
    limits.snk_curr == '0 || limits.snk_pwr == '0 |=> source_only)
    else $error("zero sink limit not source only");
  a_crank_volt: assert property (
    running && st.mode == MODE_CRANK |-> !sv_is_curr && st.seg < 7'h5)
    else $error("cranking curve left voltage");
  a_trap_wrap: assert property (
    st.state == ST_RUN && st.mode == MODE_TRAP && adv && seg_end
    |=> st.seg == {5'h0, 2'($past(st.seg[1:0]) + 2'h1)} || !running)
    else $error("trapezoid segment order broken");
  a_arb_window: assert property (
    running && st.mode == MODE_ARB |-> st.seg >= st.first &&
    st.seg <= st.last)
    else $error("point outside the block");
  a_ratio_reject: assert property (
    pt_we && !ratio_ok |=> pt_reject && !pt_accept)
    else $error("slow sweep accepted");
  a_pause_hold: assert property (
    st.state == ST_PAUSE && adv |-> sample == static_volt)
    else $error("pause not at static value");
  a_no_sine: assert property (
    cur.sine_start_freq == '0 && cur.sine_end_freq == '0
    && st.state == ST_RUN |-> sample == dc)
    else $error("sine present at zero frequency");
endmodule

// [tb/sv_sink.sv]
// stand-in for the regulation loop that takes set-value samples
// assumes the sequencer clock; stall holds ready low like a slow loop
`timescale 1ns/1ps
module sv_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic sv_valid,
  input wire logic [15:0] sv_data,
  output logic sv_ready,
  output logic [15:0] last,
  output int pops
);
  // ready is a level, so backing up the fifo needs no handshake state
  assign sv_ready = !stall && !rst;
  // keep the sample taken at each pop edge, and how many were taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last <= 16'h0000;
      pops <= 0;
    end else if (sv_valid && sv_ready) begin
      last <= sv_data;
      pops <= pops + 1;
    end
  end
endmodule

// [tb/waveform_sequencer_tb.sv]
// self-checking bench for the set-value sequencer
// assumes a four-clock sample tick and the loop stand-in as consumer
`timescale 1ns/1ps
module waveform_sequencer_tb;
  import awg_pkg::*;
  typedef struct packed {
    logic [6:0] idx;
    point_t p;
    logic ok;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  mode_t mode_sel = MODE_TRAP;
  logic tgt_curr = 1'b0;
  limits_t limits = '{16'h0064, 16'h0064, 16'h0064, 16'h0064};
  trap_cfg_t trap_cfg = '{16'sh0064, 16'sh0032, {4{29'h00000002}}};
  logic crank_we = 1'b0;
  logic [2:0] crank_idx = 3'h0;
  crank_seg_t crank_data = '0;
  logic [9:0] crank_cycles = 10'h001;
  logic [28:0] repeat_pause_time = 29'h0000000a;
  logic signed [15:0] static_volt = 16'sh0100;
  logic pt_we = 1'b0;
  logic [6:0] pt_idx = 7'h00;
  point_t pt_data = '0;
  logic [6:0] arb_first = 7'h01;
  logic [6:0] arb_last = 7'h01;
  logic [9:0] arb_cycles = 10'h001;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_off = 1'b0;
  logic alarm_pin = 1'b0;
  logic stall = 1'b0;
  logic sv_ready, sv_valid, sv_is_curr, output_on, running, sink_only;
  logic source_only, alarm_flag, pt_accept, pt_reject, start_reject;
  logic [15:0] sv_data, sink_last;
  int pops, n, p0, hi, ps;
  int err_total = 0;
  int checked = 0;
  row_t r [18];

  // short tick keeps the cranking run near eighteen thousand clocks
  waveform_sequencer #(.TICK_CYC(4)) DUT (.clk, .rst, .mode_sel,
    .tgt_curr, .limits, .trap_cfg, .crank_we, .crank_idx, .crank_data,
    .crank_cycles, .repeat_pause_time, .static_volt, .pt_we, .pt_idx,
    .pt_data, .arb_first, .arb_last, .arb_cycles, .cmd_start, .cmd_stop,
    .cmd_off, .alarm_pin, .sv_ready, .sv_data, .sv_valid, .sv_is_curr,
    .output_on, .running, .sink_only, .source_only, .alarm_flag,
    .pt_accept, .pt_reject, .start_reject);
  sv_sink sink (.clk, .rst, .stall, .sv_valid, .sv_data, .sv_ready,
    .last(sink_last), .pops);

  // 50 MHz clock
  always #10 clk = ~clk;

  function automatic row_t mk(logic [6:0] i, logic [15:0] sa, ea, so,
      logic [13:0] fe, logic [8:0] an, logic [28:0] tm, logic ok);
    mk = '{i, '{sa, ea, so, so, 14'h0, fe, an, tm}, ok};
  endfunction

  task automatic bad(input string m);
    err_total++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task automatic chk(input logic g, input logic e);
    checked++;
    if (g !== e) bad($sformatf("flag %b exp %b", g, e));
  endtask

  task automatic chkw(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) bad($sformatf("word %h exp %h", g, e));
  endtask

  task automatic final_report;
    $display("err_total %0d checked %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tmo(input int c, input int b);
    if (c >= b) begin
      bad("wait ran out");
      final_report();
    end
  endtask

  // one-cycle command pulse, state settled on return
  task automatic cmd(input int k);
    @(posedge clk);
    case (k)
      0: cmd_start <= 1'b1;
      1: cmd_stop <= 1'b1;
      default: cmd_off <= 1'b1;
    endcase
    @(posedge clk);
    {cmd_start, cmd_stop, cmd_off} <= 3'h0;
    #1;
  endtask

  task automatic wait_run(input int b);
    int c;
    for (c = 0; c < b && running !== 1'b0; c++) begin
      @(posedge clk);
      #1;
    end
    tmo(c, b);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // point table: idx 1 and idx 0x63 keep short points, only idx 1 is in the run
  initial begin
    r[0] = mk(7'h01, 16'h0, 16'h1, 16'h64, 14'h1, 9'h0, 29'ha, 1'b1);
    r[1] = mk(7'h00, 16'h0, 16'h1, 16'h64, 14'h1, 9'h0, 29'ha, 1'b0);
    r[2] = mk(7'h63, 16'h0, 16'h1, 16'h64, 14'h1, 9'h0, 29'ha, 1'b1);
    r[3] = mk(7'h64, 16'h0, 16'h1, 16'h64, 14'h1, 9'h0, 29'ha, 1'b0);
    r[4] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h2710, 9'h0, 29'ha, 1'b1);
    r[5] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h2711, 9'h0, 29'ha, 1'b0);
    r[6] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h1, 9'h167, 29'ha, 1'b1);
    r[7] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h1, 9'h168, 29'ha, 1'b0);
    r[8] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h1, 9'h0, 29'h0, 1'b0);
    r[9] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h1, 9'h0, 29'h15752a01, 1'b0);
    r[10] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h1, 9'h0, 29'h433, 1'b1);
    r[11] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h1, 9'h0, 29'h434, 1'b0);
    r[12] = mk(7'h02, 16'h1387, 16'h1388, 16'h1388, 14'h1, 9'h0, 29'ha, 1'b1);
    r[13] = mk(7'h02, 16'h1387, 16'h1389, 16'h1388, 14'h1, 9'h0, 29'ha, 1'b0);
    r[14] = mk(7'h02, 16'h64, 16'h65, 16'h63, 14'h1, 9'h0, 29'ha, 1'b0);
    r[15] = mk(7'h02, 16'h0, 16'h0, 16'h64, 14'h1, 9'h0, 29'ha, 1'b1);
    r[16] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h64, 9'h0, 29'h10000, 1'b1);
    r[17] = mk(7'h02, 16'h0, 16'h1, 16'h64, 14'h64, 9'h0, 29'h10001, 1'b0);
  end

  // main sequence: reset checks and the table loop first, then the hand-written cases
  initial begin
    settle(16);
    chk(running, 1'b0);
    chk(output_on, 1'b0);
    chk(sv_valid, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    foreach (r[k]) begin
      @(posedge clk);
      pt_we <= 1'b1;
      pt_idx <= r[k].idx;
      pt_data <= r[k].p;
      @(posedge clk);
      pt_we <= 1'b0;
      #1;
      chk(pt_accept, r[k].ok);
      chk(pt_reject, !r[k].ok);
    end
    @(posedge clk);
    limits.src_curr <= 16'h0000;
    settle(3);
    chk(sink_only, 1'b1);
    chk(source_only, 1'b0);
    @(posedge clk);
    limits <= '{16'h0064, 16'h0064, 16'h0064, 16'h0000};
    settle(3);
    chk(sink_only, 1'b0);
    chk(source_only, 1'b1);
    @(posedge clk);
    limits.snk_pwr <= 16'h0064;
    cmd(0);
    chk(running, 1'b1);
    chk(output_on, 1'b1);
    settle(20);
    cmd(1);
    chk(running, 1'b0);
    chk(output_on, 1'b1);
    settle(40);
    chkw(sink_last, static_volt);
    // stalled loop: fifo fills, head holds, then sixteen pops in a row
    @(posedge clk);
    stall <= 1'b1;
    settle(100);
    chk(sv_valid, 1'b1);
    chkw(sv_data, static_volt);
    @(posedge clk);
    stall <= 1'b0;
    p0 = pops;
    settle(16);
    chkw(16'(pops - p0), 16'h0010);
    cmd(2);
    chk(output_on, 1'b0);
    settle(40);
    chkw(sink_last, 16'h0000);
    @(posedge clk);
    mode_sel <= MODE_ARB;
    arb_first <= 7'h05;
    arb_last <= 7'h04;
    cmd(0);
    chk(start_reject, 1'b1);
    chk(running, 1'b0);
    @(posedge clk);
    arb_first <= 7'h01;
    arb_last <= 7'h01;
    tgt_curr <= 1'b1;
    cmd(0);
    chk(start_reject, 1'b0);
    chk(sv_is_curr, 1'b1);
    wait_run(400);
    @(posedge clk);
    tgt_curr <= 1'b0;
    cmd(0);
    chk(sv_is_curr, 1'b0);
    wait_run(400);
    chk(output_on, 1'b1);
    settle(40);
    @(posedge clk);
    mode_sel <= MODE_CRANK;
    cmd(0);
    for (n = 0; n < 2000 && sink_last === static_volt; n++) begin
      @(posedge clk);
      #1;
    end
    tmo(n, 2000);
    chkw(sink_last, CRANK_DEF[0].volt_start);
    chk(sv_is_curr, 1'b0);
    wait_run(20000);
    chk(output_on, 1'b1);
    settle(40);
    chkw(sink_last, static_volt);
    // alarm in mid-run, then a clean restart once the pin drops
    cmd(0);
    @(posedge clk);
    alarm_pin <= 1'b1;
    for (n = 0; n < 8 && alarm_flag !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    tmo(n, 8);
    chk(running, 1'b0);
    chk(output_on, 1'b0);
    @(posedge clk);
    alarm_pin <= 1'b0;
    settle(6);
    cmd(0);
    chk(alarm_flag, 1'b0);
    chk(running, 1'b1);
    // short flat curve run twice: each sample is seen once before its pop
    cmd(1);
    for (n = 0; n < 5; n++) begin
      @(posedge clk);
      crank_we <= 1'b1;
      crank_idx <= 3'(n);
      crank_data <= '{16'sh0200, 16'sh0200, 29'h00000002};
    end
    @(posedge clk);
    crank_we <= 1'b0;
    crank_cycles <= 10'h002;
    cmd(0);
    hi = 0;
    ps = 0;
    for (n = 0; n < 400 && running !== 1'b0; n++) begin
      @(posedge clk);
      #1;
      if (sv_valid === 1'b1 && sv_data === 16'h0200) hi++;
      if (hi > 0 && running === 1'b1 && sv_valid === 1'b1 &&
          sv_data === static_volt) ps++;
    end
    tmo(n, 400);
    chkw(16'(hi), 16'h0014);
    chkw(16'(ps), 16'h000a);
    // reset in mid-run must bring the preset curve back
    cmd(0);
    @(posedge clk);
    rst <= 1'b1;
    settle(2);
    chk(running, 1'b0);
    chk(sv_valid, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    cmd(0);
    for (n = 0; n < 200 && sink_last === 16'h0000; n++) begin
      @(posedge clk);
      #1;
    end
    tmo(n, 200);
    chkw(sink_last, CRANK_DEF[0].volt_start);
    final_report();
  end
endmodule
